// File: design/amc_ctrl_regs.vh
// Register offsets, field positions, reset values and counts for the converter control block
`ifndef AMC_CTRL_REGS_VH
`define AMC_CTRL_REGS_VH
// Register addresses on the 4-bit control port
`define AMC_ADDR_CFG      4'h0
`define AMC_ADDR_I_RANGE  4'h3
`define AMC_ADDR_ADJ      4'h4
`define AMC_ADDR_TRIM     4'h5
`define AMC_ADDR_Q_RANGE  4'hb
`define AMC_ADDR_STAT     4'he
// Configuration register bits
`define AMC_CFG_CAL_BIT   15
`define AMC_CFG_PHASE_BIT 14
`define AMC_CFG_ISLP_BIT  11
`define AMC_CFG_QSLP_BIT  10
// Calibration adjust register bits
`define AMC_ADJ_SEQ_BIT   14
`define AMC_ADJ_ACC_BIT   7
// Register reset values
`define AMC_CFG_DEF       16'h0000
`define AMC_ADJ_DEF       16'h4000
`define AMC_RANGE_DEF     16'h4000
// Range codes presented in pin-control mode
`define AMC_RANGE_HI      16'hffff
`define AMC_RANGE_LO      16'h0000
// Calibration constant array
`define AMC_TRIM_DEPTH    183
`define AMC_TRIM_AW       8
`define AMC_PTR_MAX       8'hff
// Timing counts in input clock cycles
`define AMC_CAL_L_DEF     1280
`define AMC_CAL_H_DEF     1280
`define AMC_CAL_CYC_DEF   20000
`define AMC_FLUSH_DEF     34
// Test pattern words and the ten-step sequence, one bit per step
`define AMC_PAT_I0        10'h001
`define AMC_PAT_I1        10'h3fe
`define AMC_PAT_Q0        10'h000
`define AMC_PAT_Q1        10'h3ff
`define AMC_PAT_SEQ       10'h3aa
`define AMC_PAT_LEN       4'h9
// Status register fields
`define AMC_STAT_RUN_BIT  0
`define AMC_STAT_PAU_BIT  1
`define AMC_STAT_PTR_LSB  8
`endif

// File: design/amc_trim_mem.v
// Calibration constant array with registered read data
`timescale 1ns/100ps
module amc_trim_mem #(
  parameter DEPTH = 183,
  parameter WIDTH = 16,
  parameter AW    = 8
) (
  input  wire             i_clk,
  input  wire             i_we,
  input  wire [AW-1:0]    i_waddr,
  input  wire [WIDTH-1:0] i_wdata,
  input  wire [AW-1:0]    i_raddr,
  output reg  [WIDTH-1:0] o_rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Read before write; no reset so the array maps onto plain RAM
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// File: design/amc_cal_detect.v
// Calibrate request qualifier: low for CAL_L cycles, then high for CAL_H cycles
`timescale 1ns/100ps
module amc_cal_detect #(
  parameter CAL_L = 1280,
  parameter CAL_H = 1280,
  parameter CW    = 16
) (
  input  wire i_clk,
  input  wire i_srst,
  input  wire i_req,
  output reg  o_start
);
  localparam [CW-1:0] LOW_N  = CAL_L;
  localparam [CW-1:0] HIGH_N = CAL_H;
  reg [CW-1:0] low_q;
  reg [CW-1:0] high_q;
  reg          armed_q;

  // Noise on the request cannot start a calibration: both phases must hold
  always @(posedge i_clk) begin
    if (i_srst) begin
      low_q   <= {CW{1'b0}};
      high_q  <= {CW{1'b0}};
      armed_q <= 1'b0;
      o_start <= 1'b0;
    end else begin
      o_start <= 1'b0;
      if (!i_req) begin
        high_q <= {CW{1'b0}};
        if (low_q != LOW_N) begin
          low_q <= low_q + 1'b1;
        end
        if (low_q + 1'b1 >= LOW_N) begin
          armed_q <= 1'b1; // see R14
        end
      end else begin
        low_q <= {CW{1'b0}};
        if (armed_q) begin
          high_q <= high_q + 1'b1;
          if (high_q + 1'b1 >= HIGH_N) begin
            o_start <= 1'b1; // see R14
            armed_q <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// File: design/amc_ctrl.v
// Converter control: mode pins, calibration, power-down and calibration constant access
// Overview of operation
// R1: Both channels asleep pauses calibration; resume on wake
// R2: Host recalibrates after any channel sleep change
// R3: Calibration constants kept in array at 5h
// R4: Save: access bit, 184 reads, first dummy
// R5: Restore: 183 writes, two zero dummies
// R6: Host restores only under identical conditions
// R7: Per-channel sleep is pin OR register bit
// R8: Host sets mode and calibrates after power-up
// R9: Mode pin high gives pin control, no registers
// R10: Demux pin chooses bus layout in both modes
// R11: Non-demux full rate one bus, demux two
// R12: Phase select moves data between clock edges
// R13: Register mode takes phase from bit 14
// R14: Calibrate needs low then high minimum counts
// R15: Register mode ORs calibrate pin with bit 15
// R16: Host holds calibrate request high when idle
// R17: Sleeping channel tristates outputs, then flushes pipeline
// R18: Q channel sleep independent, register bit 10
// R19: Pattern select replaces samples and overrange flags
// R20: Range pin common; registers 3h, Bh per channel
// R21: Host recalibrates after a range change
// R22: Calibration forces data low, clocks keep running
// R23: Pin mode loads all registers with defaults
// R24: Each constant access advances pointer; clear resets; here the pointer stops advancing at ff
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "amc_ctrl_regs.vh"
module amc_ctrl #(
  parameter CAL_L   = `AMC_CAL_L_DEF,
  parameter CAL_H   = `AMC_CAL_H_DEF,
  parameter CAL_CYC = `AMC_CAL_CYC_DEF,
  parameter FLUSH   = `AMC_FLUSH_DEF,
  parameter DEPTH   = `AMC_TRIM_DEPTH,
  parameter DW      = 10
) (
  input  wire          I_CORE_CLK,
  input  wire          I_SRST,
  input  wire [3:0]    I_ADDR,
  input  wire [15:0]   I_WDATA,
  input  wire          I_WR,
  input  wire          I_RD,
  output reg  [15:0]   O_RDATA,
  input  wire          I_CONTROL_MODE_SELECT_N,
  input  wire          I_DEMUX_SELECT,
  input  wire          I_OUTPUT_PHASE_SELECT,
  input  wire          I_CAL_REQ,
  input  wire          I_I_CHANNEL_SLEEP,
  input  wire          I_Q_CHANNEL_SLEEP,
  input  wire          I_PATTERN_OUTPUT_SELECT,
  input  wire          I_INPUT_RANGE_SELECT,
  input  wire [DW-1:0] I_I_SAMPLE,
  input  wire [DW-1:0] I_Q_SAMPLE,
  input  wire          I_I_OVR,
  input  wire          I_Q_OVR,
  input  wire [15:0]   I_CAL_WORD,
  output reg  [DW-1:0] O_I_DATA_A,
  output reg  [DW-1:0] O_I_DATA_B,
  output reg  [DW-1:0] O_Q_DATA_A,
  output reg  [DW-1:0] O_Q_DATA_B,
  output reg           O_I_OVERRANGE_FLAG,
  output reg           O_Q_OVERRANGE_FLAG,
  output reg           O_I_DATA_OE,
  output reg           O_Q_DATA_OE,
  output reg           O_I_VALID,
  output reg           O_Q_VALID,
  output reg           O_OUTPUT_DATA_CLOCK,
  output reg           O_REGISTER_CONTROL_MODE,
  output reg           O_CAL_RUNNING,
  output reg           O_I_POWER_DOWN,
  output reg           O_Q_POWER_DOWN,
  output reg  [15:0]   O_I_RANGE,
  output reg  [15:0]   O_Q_RANGE,
  output reg           O_TRIM_SEQUENCE_SELECT
);
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_RUN   = 2'd1;
  localparam [1:0] ST_PAUSE = 2'd2;
  localparam [19:0] CAL_N   = CAL_CYC;
  localparam [7:0]  FLUSH_N = FLUSH;
  localparam [7:0]  DEPTH_N = DEPTH;

  // Output word: calibration wins, then pattern, then converted sample
  function [DW:0] out_word;
    input          cal;
    input          pat;
    input [DW:0]   pat_w;
    input [DW:0]   smp_w;
    begin
      out_word = cal ? {(DW+1){1'b0}} : (pat ? pat_w : smp_w);
    end
  endfunction

  reg  [15:0]   cfg_q;
  reg  [15:0]   adj_q;
  reg  [15:0]   irng_q;
  reg  [15:0]   qrng_q;
  reg  [7:0]    ptr_q;
  reg  [7:0]    ptr_d;
  reg  [1:0]    state_q;
  reg  [19:0]   cal_cnt_q;
  reg  [1:0]    tick_q;
  reg           half_q;
  reg  [3:0]    pat_q;
  reg  [7:0]    iflush_q;
  reg  [7:0]    qflush_q;
  wire          register_control_mode;
  wire          islp;
  wire          qslp;
  wire          cal_req;
  wire          cal_start;
  wire          cal_on;
  wire          phase;
  wire          load;
  wire          acc;
  wire          acc_hit;
  wire          cal_we;
  wire          mem_we;
  wire [7:0]    mem_waddr;
  wire [15:0]   mem_wdata;
  wire [7:0]    mem_raddr;
  wire [15:0]   mem_rdata;
  wire          pat_bit;
  wire [DW:0]   iw;
  wire [DW:0]   qw;

  // Mode pin low selects register control; pin mode ignores the port
  assign register_control_mode     = ~I_CONTROL_MODE_SELECT_N;                        // see R9
  assign islp    = I_I_CHANNEL_SLEEP | (register_control_mode & cfg_q[`AMC_CFG_ISLP_BIT]); // see R7
  assign qslp    = I_Q_CHANNEL_SLEEP | (register_control_mode & cfg_q[`AMC_CFG_QSLP_BIT]); // see R18
  assign cal_req = I_CAL_REQ | (register_control_mode & cfg_q[`AMC_CFG_CAL_BIT]);     // see R15
  assign phase   = register_control_mode ? cfg_q[`AMC_CFG_PHASE_BIT] : I_OUTPUT_PHASE_SELECT; // see R13
  assign cal_on  = (state_q != ST_IDLE);
  assign acc     = register_control_mode & adj_q[`AMC_ADJ_ACC_BIT];
  assign acc_hit = acc & (I_WR | I_RD) & (I_ADDR == `AMC_ADDR_TRIM);

  amc_cal_detect #(
    .CAL_L (CAL_L),
    .CAL_H (CAL_H),
    .CW    (16)
  ) u_det (
    .i_clk   (I_CORE_CLK),
    .i_srst  (I_SRST),
    .i_req   (cal_req),
    .o_start (cal_start)
  );

  // Register file; pin mode holds every register at its default
  always @(posedge I_CORE_CLK) begin
    if (I_SRST || !register_control_mode) begin
      cfg_q  <= `AMC_CFG_DEF;   // see R23
      adj_q  <= `AMC_ADJ_DEF;   // see R23
      irng_q <= `AMC_RANGE_DEF;
      qrng_q <= `AMC_RANGE_DEF;
    end else if (I_WR) begin
      case (I_ADDR)
        `AMC_ADDR_CFG:     cfg_q <= I_WDATA;
        `AMC_ADDR_ADJ:     adj_q <= I_WDATA;
        `AMC_ADDR_I_RANGE: irng_q <= I_WDATA;   // see R20
        `AMC_ADDR_Q_RANGE: qrng_q <= I_WDATA;   // see R20
        default:           cfg_q <= cfg_q;
      endcase
    end
  end

  // Array pointer: every access moves it on until it reaches ff, clearing access resets it
  always @* begin
    ptr_d = ptr_q;
    if (!acc) begin
      ptr_d = 8'h00;            // see R24
    end else if (acc_hit && ptr_q != `AMC_PTR_MAX) begin
      ptr_d = ptr_q + 8'h01;    // see R24
    end
  end

  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      ptr_q <= 8'h00;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // Calibration fills the array; bus restore writes land at the pointer
  assign cal_we    = (state_q == ST_RUN) && (cal_cnt_q < {12'h000, DEPTH_N}); // see R3
  assign mem_we    = cal_we | (acc_hit & I_WR & (ptr_q < DEPTH_N) & ~cal_on); // see R5
  assign mem_waddr = cal_we ? cal_cnt_q[7:0] : ptr_q;
  assign mem_wdata = cal_we ? I_CAL_WORD : I_WDATA;
  // Read address follows the next pointer so back-to-back reads stay in step
  assign mem_raddr = (ptr_d == 8'h00) ? 8'h00 : ptr_d - 8'h01;

  amc_trim_mem #(
    .DEPTH (DEPTH),
    .WIDTH (16),
    .AW    (`AMC_TRIM_AW)
  ) u_mem (
    .i_clk   (I_CORE_CLK),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata)
  );

  // Read data one cycle after the strobe; unmapped or pin mode read zero
  always @(posedge I_CORE_CLK) begin
    if (I_SRST || !I_RD || !register_control_mode) begin
      O_RDATA <= 16'h0000;
    end else begin
      case (I_ADDR)
        `AMC_ADDR_CFG:     O_RDATA <= cfg_q;
        `AMC_ADDR_ADJ:     O_RDATA <= adj_q;
        `AMC_ADDR_I_RANGE: O_RDATA <= irng_q;
        `AMC_ADDR_Q_RANGE: O_RDATA <= qrng_q;
        `AMC_ADDR_TRIM: begin
          // First read after enabling access is the dummy word
          if (acc && ptr_q != 8'h00 && ptr_q <= DEPTH_N) begin
            O_RDATA <= mem_rdata; // see R4
          end else begin
            O_RDATA <= 16'h0000;  // see R4
          end
        end
        `AMC_ADDR_STAT:    O_RDATA <= {ptr_q, 6'h00, (state_q == ST_PAUSE), cal_on};
        default:           O_RDATA <= 16'h0000;
      endcase
    end
  end

  // Calibration sequencer; both channels asleep freezes it where it stands
  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      state_q   <= ST_IDLE;
      cal_cnt_q <= 20'h00000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cal_cnt_q <= 20'h00000;
          if (cal_start) begin
            state_q <= ST_RUN;      // see R14
          end
        end
        ST_RUN: begin
          if (islp && qslp) begin
            state_q <= ST_PAUSE;    // see R1
          end else if (cal_cnt_q + 20'h00001 >= CAL_N) begin
            state_q <= ST_IDLE;
          end else begin
            cal_cnt_q <= cal_cnt_q + 20'h00001;
          end
        end
        ST_PAUSE: begin
          if (!islp || !qslp) begin
            state_q <= ST_RUN;      // see R1
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Output clock toggles every second core cycle and never stops
  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      tick_q              <= 2'b00;
      O_OUTPUT_DATA_CLOCK <= 1'b0;
    end else begin
      tick_q <= tick_q + 2'b01;
      if (tick_q[0]) begin
        O_OUTPUT_DATA_CLOCK <= ~O_OUTPUT_DATA_CLOCK; // see R22
      end
    end
  end

  // Phase low: data moves with the clock edge; high: halfway between edges
  assign load    = phase ? ~tick_q[0] : tick_q[0]; // see R12
  assign pat_bit = |((`AMC_PAT_SEQ >> pat_q) & 10'h001); // One step of the sequence
  assign iw = out_word(cal_on, I_PATTERN_OUTPUT_SELECT,
                       pat_bit ? {1'b1, `AMC_PAT_I1} : {1'b0, `AMC_PAT_I0},
                       {I_I_OVR, I_I_SAMPLE});     // see R19
  assign qw = out_word(cal_on, I_PATTERN_OUTPUT_SELECT,
                       pat_bit ? {1'b1, `AMC_PAT_Q1} : {1'b0, `AMC_PAT_Q0},
                       {I_Q_OVR, I_Q_SAMPLE});     // see R19

  // Data buses: demux alternates two half-rate buses, non-demux uses one
  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      half_q             <= 1'b0;
      pat_q              <= 4'h0;
      O_I_DATA_A         <= {DW{1'b0}};
      O_I_DATA_B         <= {DW{1'b0}};
      O_Q_DATA_A         <= {DW{1'b0}};
      O_Q_DATA_B         <= {DW{1'b0}};
      O_I_OVERRANGE_FLAG <= 1'b0;
      O_Q_OVERRANGE_FLAG <= 1'b0;
    end else if (load) begin
      half_q <= I_DEMUX_SELECT ? 1'b0 : ~half_q;   // see R10
      pat_q  <= (pat_q == `AMC_PAT_LEN) ? 4'h0 : pat_q + 4'h1;
      O_I_OVERRANGE_FLAG <= iw[DW];                // see R22
      O_Q_OVERRANGE_FLAG <= qw[DW];                // see R22
      if (I_DEMUX_SELECT || !half_q || cal_on) begin
        O_I_DATA_A <= iw[DW-1:0];                  // see R11
        O_Q_DATA_A <= qw[DW-1:0];
      end else begin
        O_I_DATA_B <= iw[DW-1:0];                  // see R11
        O_Q_DATA_B <= qw[DW-1:0];
      end
      if (I_DEMUX_SELECT || cal_on) begin
        O_I_DATA_B <= {DW{1'b0}};                  // see R22
        O_Q_DATA_B <= {DW{1'b0}};
      end
    end
  end

  // Sleep drops the enables; on wake valid stays low until the pipeline flush count runs out
  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_I_DATA_OE <= 1'b0;
      O_Q_DATA_OE <= 1'b0;
      O_I_VALID   <= 1'b0;
      O_Q_VALID   <= 1'b0;
      iflush_q    <= FLUSH_N;
      qflush_q    <= FLUSH_N;
    end else begin
      O_I_DATA_OE <= ~islp;                        // see R17
      O_Q_DATA_OE <= ~qslp;                        // see R18
      if (islp) begin
        iflush_q <= FLUSH_N;                       // see R17
      end else if (iflush_q != 8'h00) begin
        iflush_q <= iflush_q - 8'h01;
      end
      if (qslp) begin
        qflush_q <= FLUSH_N;                       // see R18
      end else if (qflush_q != 8'h00) begin
        qflush_q <= qflush_q - 8'h01;
      end
      O_I_VALID <= ~islp & (iflush_q == 8'h00) & ~cal_on;
      O_Q_VALID <= ~qslp & (qflush_q == 8'h00) & ~cal_on;
    end
  end

  // Status and effective settings, all registered
  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_REGISTER_CONTROL_MODE <= 1'b0;
      O_CAL_RUNNING           <= 1'b0;
      O_I_POWER_DOWN          <= 1'b0;
      O_Q_POWER_DOWN          <= 1'b0;
      O_I_RANGE               <= `AMC_RANGE_DEF;
      O_Q_RANGE               <= `AMC_RANGE_DEF;
      O_TRIM_SEQUENCE_SELECT  <= 1'b1;
    end else begin
      O_REGISTER_CONTROL_MODE <= register_control_mode;
      O_CAL_RUNNING           <= cal_on;
      O_I_POWER_DOWN          <= islp;             // see R7
      O_Q_POWER_DOWN          <= qslp;             // see R18
      O_TRIM_SEQUENCE_SELECT  <= adj_q[`AMC_ADJ_SEQ_BIT];
      if (register_control_mode) begin
        O_I_RANGE <= irng_q;                       // see R20
        O_Q_RANGE <= qrng_q;
      end else begin
        // One pin sets a common range for both channels
        O_I_RANGE <= I_INPUT_RANGE_SELECT ? `AMC_RANGE_HI : `AMC_RANGE_LO; // see R20
        O_Q_RANGE <= I_INPUT_RANGE_SELECT ? `AMC_RANGE_HI : `AMC_RANGE_LO;
      end
    end
  end
endmodule

// File: bench/amc_ctrl_sva.sv
// Concurrent checks on the converter control block ports
`timescale 1ns/100ps
module amc_ctrl_sva #(
  parameter CAL_L = 4,
  parameter CAL_H = 4
) (
  input wire        I_CORE_CLK,
  input wire        I_SRST,
  input wire        I_RD,
  input wire        I_CONTROL_MODE_SELECT_N,
  input wire        I_DEMUX_SELECT,
  input wire        I_CAL_REQ,
  input wire        I_I_CHANNEL_SLEEP,
  input wire        I_Q_CHANNEL_SLEEP,
  input wire [15:0] O_RDATA,
  input wire [9:0]  O_I_DATA_A,
  input wire [9:0]  O_I_DATA_B,
  input wire [9:0]  O_Q_DATA_A,
  input wire [9:0]  O_Q_DATA_B,
  input wire        O_I_OVERRANGE_FLAG,
  input wire        O_I_DATA_OE,
  input wire        O_OUTPUT_DATA_CLOCK,
  input wire        O_REGISTER_CONTROL_MODE,
  input wire        O_CAL_RUNNING,
  input wire        O_I_POWER_DOWN,
  input wire        O_Q_POWER_DOWN
);
  // One clock domain; everything is off while reset is high
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);
  // Register port is dead in pin mode, so reads return zero
  a_pin_rdata: assert property ($past(I_RD && I_CONTROL_MODE_SELECT_N) |-> O_RDATA == 16'h0000)
    else $error("read data not zero in pin mode");
  a_mode_flag: assert property (!$past(I_SRST) |-> O_REGISTER_CONTROL_MODE == !$past(I_CONTROL_MODE_SELECT_N))
    else $error("control mode flag does not follow mode pin");
  a_i_sleep: assert property (!$past(I_SRST) && $past(I_I_CHANNEL_SLEEP) |-> O_I_POWER_DOWN)
    else $error("I channel pin sleep not applied");
  a_q_sleep: assert property (!$past(I_SRST) && $past(I_Q_CHANNEL_SLEEP) |-> O_Q_POWER_DOWN)
    else $error("Q channel pin sleep not applied");
  // Two cycles of sleep cover either register depth of the enable
  a_sleep_hiz: assert property (O_I_POWER_DOWN && $past(O_I_POWER_DOWN) |-> !O_I_DATA_OE)
    else $error("sleeping I channel still drives");
  a_cal_blank: assert property (O_CAL_RUNNING && $past(O_CAL_RUNNING) && $past(O_CAL_RUNNING, 2) && !O_I_POWER_DOWN
    |-> O_I_DATA_A == 10'h000 && O_Q_DATA_A == 10'h000 && !O_I_OVERRANGE_FLAG)
    else $error("data not held low during calibration");
  a_clk_runs: assert property ($rose(O_OUTPUT_DATA_CLOCK) |=> O_OUTPUT_DATA_CLOCK ##1 !O_OUTPUT_DATA_CLOCK
    ##1 !O_OUTPUT_DATA_CLOCK ##1 O_OUTPUT_DATA_CLOCK)
    else $error("output data clock stopped or off rate");
  a_nondemux_b: assert property ($past(I_DEMUX_SELECT) && $past(I_DEMUX_SELECT, 2) && $past(I_DEMUX_SELECT, 3)
    |-> O_I_DATA_B == 10'h000 && O_Q_DATA_B == 10'h000)
    else $error("second bus active in non-demux mode");
  a_cal_start: assert property ((!I_CAL_REQ) [*4] ##1 I_CAL_REQ [*4] |-> ##[0:6] O_CAL_RUNNING)
    else $error("qualified calibrate request did not start a run");
  a_cal_pause: assert property (O_CAL_RUNNING && O_I_POWER_DOWN && O_Q_POWER_DOWN |=> O_CAL_RUNNING)
    else $error("calibration lost while both channels asleep");
endmodule
bind amc_ctrl amc_ctrl_sva #(.CAL_L(CAL_L), .CAL_H(CAL_H)) u_amc_ctrl_sva (.*);

// File: bench/amc_host_model.sv
// Host controller model driving the calibrate request pin
`timescale 1ns/100ps
module amc_host_model #(
  parameter LO = 4
) (
  input  wire i_clk,
  output reg  o_cal_req
);
  // Idle level is high so that noise never arms a calibration
  initial o_cal_req = 1'b1;
  // Request low; changes land just after an edge
  task automatic drop;
    begin
      @(posedge i_clk) o_cal_req <= 1'b0;
    end
  endtask
  // Back to idle, held high well past the minimum high count
  task automatic raise;
    begin
      @(posedge i_clk) o_cal_req <= 1'b1;
    end
  endtask
  // Whole request: low for the minimum plus extra, then high
  task automatic pulse(input int extra);
    begin
      drop();
      repeat (LO + extra) @(posedge i_clk);
      o_cal_req <= 1'b1;
    end
  endtask
endmodule

// File: bench/amc_ctrl_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module amc_ctrl_test;
  reg          I_CORE_CLK = 1'b0;
  reg          I_SRST = 1'b1;
  reg  [3:0]   I_ADDR = 4'h0;
  reg  [15:0]  I_WDATA = 16'h0000;
  reg          I_WR = 1'b0;
  reg          I_RD = 1'b0;
  reg          I_CONTROL_MODE_SELECT_N = 1'b1;
  reg          I_DEMUX_SELECT = 1'b1;
  reg          I_OUTPUT_PHASE_SELECT = 1'b0;
  reg          I_I_CHANNEL_SLEEP = 1'b0;
  reg          I_Q_CHANNEL_SLEEP = 1'b0;
  reg          I_PATTERN_OUTPUT_SELECT = 1'b0;
  reg          I_INPUT_RANGE_SELECT = 1'b0;
  reg  [9:0]   I_I_SAMPLE = 10'h155;
  reg  [9:0]   I_Q_SAMPLE = 10'h2aa;
  reg          I_I_OVR = 1'b0;
  reg          I_Q_OVR = 1'b0;
  reg  [15:0]  I_CAL_WORD = 16'h0000;
  wire         I_CAL_REQ;
  wire [15:0]  O_RDATA, O_I_RANGE, O_Q_RANGE;
  wire [9:0]   O_I_DATA_A, O_I_DATA_B, O_Q_DATA_A, O_Q_DATA_B;
  wire         O_I_OVERRANGE_FLAG, O_Q_OVERRANGE_FLAG, O_I_DATA_OE, O_Q_DATA_OE, O_I_VALID, O_Q_VALID;
  wire         O_OUTPUT_DATA_CLOCK, O_REGISTER_CONTROL_MODE, O_CAL_RUNNING, O_I_POWER_DOWN, O_Q_POWER_DOWN;
  wire         O_TRIM_SEQUENCE_SELECT;
  int          num_errors = 0;
  int          total_checks = 0;
  // Short counts keep each calibration to a few hundred cycles
  amc_ctrl #(.CAL_L(4), .CAL_H(4), .CAL_CYC(300), .FLUSH(4)) u_amc_ctrl (.*);
  amc_host_model #(.LO(4)) u_amc_host_model (.i_clk(I_CORE_CLK), .o_cal_req(I_CAL_REQ));
  // 40 MHz core clock
  always #12.5 I_CORE_CLK = ~I_CORE_CLK;
  task automatic cyc(input int n);
    begin
      repeat (n) @(posedge I_CORE_CLK);
      #1;
    end
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      total_checks++;
      if (got !== exp) begin
        num_errors++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One-cycle strobes; the slave never stalls
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    begin
      @(posedge I_CORE_CLK);
      I_WR <= 1'b1;
      I_ADDR <= a;
      I_WDATA <= d;
      @(posedge I_CORE_CLK);
      I_WR <= 1'b0;
    end
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    begin
      @(posedge I_CORE_CLK);
      I_RD <= 1'b1;
      I_ADDR <= a;
      @(posedge I_CORE_CLK);
      I_RD <= 1'b0;
      #1;
      chk(O_RDATA, exp);
    end
  endtask
  task automatic wait_cal(input logic lvl);
    int i;
    begin
      for (i = 0; i < 400 && O_CAL_RUNNING !== lvl; i++) cyc(1);
      chk(O_CAL_RUNNING, lvl);
    end
  endtask
  task automatic t_power_up;
    begin
      cyc(2);
      chk(O_REGISTER_CONTROL_MODE, 1'b0);
      chk(O_I_RANGE, 16'h0000);
      u_amc_host_model.pulse(0);
      wait_cal(1'b1);
      cyc(4);
      chk({O_I_DATA_A, O_I_OVERRANGE_FLAG}, 11'h000);
      wait_cal(1'b0);
      cyc(12);
      chk({O_I_VALID, O_Q_VALID}, 2'b11);
    end
  endtask
  task automatic t_range;
    begin
      @(posedge I_CORE_CLK) I_INPUT_RANGE_SELECT <= 1'b1;
      cyc(3);
      chk(O_Q_RANGE, 16'hffff);
      @(posedge I_CORE_CLK) I_CONTROL_MODE_SELECT_N <= 1'b0;
      cyc(3);
      chk(O_REGISTER_CONTROL_MODE, 1'b1);
      rdc(4'h0, 16'h0000);
      rdc(4'h4, 16'h4000);
      chk(O_TRIM_SEQUENCE_SELECT, 1'b1);
      wr(4'h3, 16'h1234);
      wr(4'hb, 16'h00ab);
      rdc(4'h7, 16'h0000);
      chk(O_I_RANGE, 16'h1234);
      chk(O_Q_RANGE, 16'h00ab);
      @(posedge I_CORE_CLK) I_CONTROL_MODE_SELECT_N <= 1'b1;
      cyc(2);
      rdc(4'h3, 16'h0000);
      chk(O_I_RANGE, 16'hffff);
      @(posedge I_CORE_CLK) I_CONTROL_MODE_SELECT_N <= 1'b0;
      cyc(2);
      rdc(4'h3, 16'h4000);
    end
  endtask
  task automatic t_sleep;
    int i;
    begin
      wr(4'h0, 16'h0800);
      cyc(3);
      chk({O_I_POWER_DOWN, O_I_DATA_OE, O_Q_DATA_OE}, 3'b101);
      wr(4'h0, 16'h0400);
      cyc(3);
      chk({O_I_POWER_DOWN, O_Q_POWER_DOWN}, 2'b01);
      wr(4'h0, 16'h0000);
      @(posedge I_CORE_CLK) I_I_CHANNEL_SLEEP <= 1'b1;
      cyc(3);
      chk({O_I_POWER_DOWN, O_Q_POWER_DOWN}, 2'b10);
      @(posedge I_CORE_CLK) I_I_CHANNEL_SLEEP <= 1'b0;
      cyc(2);
      chk(O_I_VALID, 1'b0);
      for (i = 0; i < 12 && O_I_VALID !== 1'b1; i++) cyc(1);
      chk(O_I_VALID, 1'b1);
    end
  endtask
  // Register-started run, paused by sleeping both channels
  task automatic t_cal_pause;
    begin
      u_amc_host_model.drop();
      cyc(6);
      wr(4'h0, 16'h8000);
      u_amc_host_model.raise();
      wait_cal(1'b1);
      @(posedge I_CORE_CLK) I_I_CHANNEL_SLEEP <= 1'b1;
      I_Q_CHANNEL_SLEEP <= 1'b1;
      cyc(3);
      rdc(4'he, 16'h0003);
      @(posedge I_CORE_CLK) I_I_CHANNEL_SLEEP <= 1'b0;
      cyc(3);
      rdc(4'he, 16'h0001);
      wr(4'h0, 16'h0000);
      @(posedge I_CORE_CLK) I_Q_CHANNEL_SLEEP <= 1'b0;
      wait_cal(1'b0);
      u_amc_host_model.pulse(2);
      wait_cal(1'b1);
      wait_cal(1'b0);
    end
  endtask
  // Restore then save; conditions are unchanged in between
  task automatic t_trim;
    int k;
    begin
      wr(4'h4, 16'h4080);
      for (k = 0; k < 183; k++) wr(4'h5, 16'h2000 + k[15:0]);
      wr(4'h5, 16'h0000);
      wr(4'h5, 16'h0000);
      wr(4'h4, 16'h4000);
      wr(4'h4, 16'h4080);
      rdc(4'h5, 16'h0000);
      for (k = 0; k < 183; k++) rdc(4'h5, 16'h2000 + k[15:0]);
      wr(4'h4, 16'h4000);
      rdc(4'he, 16'h0000);
    end
  endtask
  task automatic t_data;
    int i;
    begin
      @(posedge I_CORE_CLK) I_CONTROL_MODE_SELECT_N <= 1'b1;
      cyc(8);
      chk(O_I_DATA_A, 10'h155);
      chk(O_Q_DATA_A, 10'h2aa);
      @(posedge I_CORE_CLK) I_DEMUX_SELECT <= 1'b0;
      I_I_OVR <= 1'b1;
      I_Q_OVR <= 1'b1;
      cyc(8);
      chk(O_I_DATA_B, 10'h155);
      chk(O_Q_DATA_B, 10'h2aa);
      chk({O_I_OVERRANGE_FLAG, O_Q_OVERRANGE_FLAG}, 2'b11);
      @(posedge I_CORE_CLK) I_DEMUX_SELECT <= 1'b1;
      I_PATTERN_OUTPUT_SELECT <= 1'b1;
      cyc(6);
      for (i = 0; i < 20; i++) begin
        chk(O_I_DATA_A == 10'h001 || O_I_DATA_A == 10'h3fe, 1'b1);
        chk({O_Q_DATA_A, O_I_OVERRANGE_FLAG}, O_I_DATA_A == 10'h3fe ? 11'h7ff : 11'h000);
        cyc(1);
      end
      t_phase(1'b0);
      t_phase(1'b1);
    end
  endtask
  // Data moves with the clock edge at phase low, halfway between edges at phase high
  task automatic t_phase(input logic ph);
    logic [9:0] pd;
    logic       pc;
    int         i;
    begin
      @(posedge I_CORE_CLK) I_OUTPUT_PHASE_SELECT <= ph;
      cyc(6);
      pd = O_I_DATA_A;
      pc = O_OUTPUT_DATA_CLOCK;
      for (i = 0; i < 24; i++) begin
        cyc(1);
        if (O_I_DATA_A !== pd) chk(O_OUTPUT_DATA_CLOCK !== pc, !ph);
        pd = O_I_DATA_A;
        pc = O_OUTPUT_DATA_CLOCK;
      end
    end
  endtask
  task automatic complete_run;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Main sequence; pin mode first so registers start from defaults
  initial begin
    repeat (16) @(posedge I_CORE_CLK);
    I_SRST <= 1'b0;
    t_power_up();
    t_range();
    t_sleep();
    t_cal_pause();
    t_trim();
    t_data();
    complete_run();
  end
  // Watchdog: the sequence needs about 2000 cycles
  initial begin
    #(25 * 20000);
    num_errors++;
    complete_run();
  end
endmodule
